// ### rtl/udr_params.svh
// Constants for the dual-role USB host interface: port offsets, field positions, reset values and timing.
// Assumes a 50 MHz core clock; the SOF pulse and frame counts are derived from the period below, the SOF slack is given in cycles.
`ifndef UDR_PARAMS_SVH
`define UDR_PARAMS_SVH
`define UDR_CLK_PERIOD_NS    20
`define UDR_ADDR_STATUS      7'h00
`define UDR_ADDR_CPU_FIFO    7'h10
`define UDR_ADDR_DMA0_FIFO   7'h11
`define UDR_ADDR_DMA1_FIFO   7'h12
`define UDR_SRC_OFF          3'h0
`define UDR_PIPE_COUNT       10
`define UDR_PIPE_CTRL        4'h0
`define UDR_PIPE_SEL_LAST    4'h2
`define UDR_PIPE_BULK_LAST   4'h5
`define UDR_PIPE_INT_LAST    4'h9
`define UDR_ST_ROLE          0
`define UDR_ST_SPEED_LO      1
`define UDR_ST_MUX           3
`define UDR_ST_RX_VALID      4
`define UDR_ST_TX_READY      5
`define UDR_SYNC_FILL        3'h5
`define UDR_SOF_PULSE_NS     640
`define UDR_SOF_PULSE_CYC    ((`UDR_SOF_PULSE_NS + `UDR_CLK_PERIOD_NS - 1) / `UDR_CLK_PERIOD_NS)
`define UDR_FS_FRAME_NS      1000000
`define UDR_FS_FRAME_CYC     (`UDR_FS_FRAME_NS / `UDR_CLK_PERIOD_NS)
`define UDR_HS_FRAME_NS      125000
`define UDR_HS_FRAME_CYC     (`UDR_HS_FRAME_NS / `UDR_CLK_PERIOD_NS)
`define UDR_SOF_SLACK_CYC    64
`define UDR_REF_12MHZ        2'h0
`define UDR_REF_24MHZ        2'h1
`define UDR_REF_48MHZ        2'h2
`define UDR_PLL_MULT_12      6'h28
`define UDR_PLL_MULT_24      6'h14
`define UDR_PLL_MULT_48      6'h0A
`endif

// ### rtl/udr_pkg.sv
// Types shared by the dual-role USB host interface modules.
// Assumes udr_params.svh supplies the numeric constants.
package udr_pkg;
	typedef enum logic [1:0] {SPD_FULL, SPD_HIGH, SPD_LOW} udr_speed_t;
	typedef enum logic [1:0] {PK_CTRL, PK_SELECT, PK_BULK, PK_INTR} udr_pipe_kind_t;
	typedef enum logic [1:0] {DMA_IDLE, DMA_REQ, DMA_GAP, DMA_DONE} udr_dma_state_t;
	typedef struct packed {
		logic [2:0] source;
		logic       ackOnly;
		logic       endEnable;
		logic       burst;
		logic       outSetup;
		logic [3:0] pipe;
	} udr_dma_cfg_t;
	typedef struct packed {
		logic        csN;
		logic        rdN;
		logic        wrLoN;
		logic        wrHiN;
		logic        ale;
		logic        busSel;
		logic [1:0]  dackN;
		logic [1:0]  dendN;
		logic [6:0]  wordAddr;
		logic [15:0] hostData;
		logic [7:0]  splitData;
	} udr_pins_t;
	localparam udr_pins_t PINS_IDLE = '{csN: 1'b1, rdN: 1'b1, wrLoN: 1'b1, wrHiN: 1'b1, ale: 1'b0,
		busSel: 1'b0, dackN: 2'h3, dendN: 2'h3, wordAddr: 7'h00, hostData: 16'h0000, splitData: 8'h00};
endpackage : udr_pkg

// ### rtl/udr_sync.sv
// Three-stage input synchroniser with agreement filter for asynchronous pins.
// Assumes each bit may change at any time relative to clk.
`timescale 1ns/1ps
module udr_sync #(
	parameter int              WIDTH   = 8,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// Clock and reset.
	input  wire logic             clk,
	input  wire logic             rst,
	// Pin side and synchronised side.
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_reg  <= RST_VAL;
			s2_reg  <= RST_VAL;
			s3_reg  <= RST_VAL;
			syncOut <= RST_VAL;
		end else begin
			s1_reg  <= pinIn;
			s2_reg  <= s1_reg;
			s3_reg  <= s2_reg;
			// A bit only moves once the last two stages agree, which filters single-cycle glitches.
			syncOut <= (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & syncOut);
		end
	end
endmodule : udr_sync

// ### rtl/udr_fifo.sv
// Synchronous FIFO with valid/ready on both sides and registered full and empty flags.
// Assumes flush is a single-cycle request from the same clock domain.
`timescale 1ns/1ps
module udr_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// Clock and reset.
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             flush,
	// Fill side.
	input  wire logic             inValid,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  inReady,
	// Drain side.
	output logic                  outValid,
	output logic      [WIDTH-1:0] outData,
	input  wire logic             outReady
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
		$error("udr_fifo DEPTH must be a power of two of at least 2");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_reg;
	logic [AW-1:0]    rdPtr_reg;
	logic [AW:0]      count_reg;
	logic [AW:0]      count_next;
	logic             push;
	logic             pop;

	assign push       = inValid && inReady;
	assign pop        = outValid && outReady;
	assign outData    = mem[rdPtr_reg];
	assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr_reg] <= inData;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
			inReady   <= 1'b1;
			outValid  <= 1'b0;
		end else if (flush) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
			inReady   <= 1'b1;
			outValid  <= 1'b0;
		end else begin
			wrPtr_reg <= wrPtr_reg + AW'(push);
			rdPtr_reg <= rdPtr_reg + AW'(pop);
			count_reg <= count_next;
			inReady   <= count_next != (AW+1)'(DEPTH);
			outValid  <= count_next != '0;
		end
	end
endmodule : udr_fifo

// ### rtl/udr_host_if.sv
// System-side front end of a dual-role USB controller: CPU bus, two DMA channels, events, SOF pulse, PLL setup.
// Assumes the USB core supplies receive data, SOF and reset indications on clk; all pins arrive asynchronously.
`timescale 1ns/1ps
`include "udr_params.svh"
module udr_host_if
	import udr_pkg::*;
#(
	parameter int FIFO_WIDTH   = 16,
	parameter int FIFO_DEPTH   = 16,
	parameter int FS_FRAME_CYC = `UDR_FS_FRAME_CYC,
	parameter int HS_FRAME_CYC = `UDR_HS_FRAME_CYC
) (
	// Clock and reset.
	input  wire logic                    clk,
	input  wire logic                    rst,
	// CPU and DMA pins, raw and asynchronous.
	input  udr_pins_t                    pinIn,
	output logic      [15:0]             hostDataOut,
	output logic                         hostDataOe,
	output logic      [7:0]              splitDataOut,
	output logic                         splitDataOe,
	output logic      [1:0]              dmaReqN,
	output logic                         sofPulseN,
	output logic                         irqN,
	// Software control inputs.
	input  wire logic                    hostRole,
	input  wire logic                    byteSwap,
	input  udr_dma_cfg_t [1:0]           dmaCfg,
	input  wire logic [1:0]              isoSelect,
	input  wire logic [1:0]              refClkSel,
	input  wire logic [5:0]              eventEnable,
	input  wire logic [5:0]              eventClear,
	// Status outputs.
	output logic      [5:0]              eventStatus,
	output udr_speed_t                   speed,
	output logic                         muxBusMode,
	output logic      [5:0]              pllMult,
	output logic                         pllCfgError,
	output udr_pipe_kind_t               usbPipeKind,
	output logic                         usbDoubleBuf,
	// USB core side.
	input  wire logic [3:0]              usbPipe,
	input  wire logic                    usbRxValid,
	input  wire logic [FIFO_WIDTH-1:0]   usbRxData,
	output logic                         usbRxReady,
	input  wire logic                    usbRxZlp,
	output logic                         usbTxValid,
	output logic      [FIFO_WIDTH-1:0]   usbTxData,
	input  wire logic                    usbTxReady,
	input  wire logic                    lineDp,
	input  wire logic                    lineDm,
	input  wire logic                    chirpSeen,
	input  wire logic                    busResetActive,
	input  wire logic                    sofSent,
	input  wire logic                    sofRxGood,
	input  wire logic                    sofRxBad
);
	localparam int FRAME_W = $clog2(FS_FRAME_CYC + `UDR_SOF_SLACK_CYC + 1);
	localparam int PULSE_W = $clog2(`UDR_SOF_PULSE_CYC + 1);
	if (FIFO_WIDTH != 16 || HS_FRAME_CYC >= FS_FRAME_CYC || HS_FRAME_CYC < 2) begin : g_param_check
		$error("udr_host_if needs a 16-bit FIFO and a high-speed frame shorter than full-speed");
	end

	function automatic udr_pipe_kind_t pipeKind(input logic [3:0] pipe);
		if (pipe == `UDR_PIPE_CTRL) begin
			return PK_CTRL;
		end else if (pipe <= `UDR_PIPE_SEL_LAST) begin
			return PK_SELECT;
		end else if (pipe <= `UDR_PIPE_BULK_LAST) begin
			return PK_BULK;
		end else begin
			return PK_INTR;
		end
	endfunction : pipeKind

	function automatic logic [15:0] swapIf(input logic [15:0] word, input logic doSwap);
		return doSwap ? {word[7:0], word[15:8]} : word;
	endfunction : swapIf

	udr_pins_t  pins;
	logic [2:0] fillCnt_reg;
	logic       strobeLow;
	logic       strobeLow_reg;
	logic       strobeEnd;
	logic       accRead_reg;
	logic       accWrLo_reg;
	logic       accWrHi_reg;
	logic       accCs_reg;
	logic [1:0] accDack_reg;
	logic [6:0] muxAddr_reg;
	logic [6:0] accAddr;
	logic [15:0] wrData_reg;
	logic [7:0] splitWr_reg;
	logic       rxPop;
	logic       txPush;
	logic [15:0] txWord;
	logic       rxValid;
	logic [15:0] rxHead;
	logic       txReady;
	logic       fifoFlush;
	logic [1:0] chanAcc;
	logic [1:0] chanReady;
	logic [1:0] chanEnd;
	logic [5:0] eventSet;
	logic       chirp_reg;
	logic       resetPrev_reg;
	logic [FRAME_W-1:0] frameCnt_reg;
	logic       frameLock_reg;
	logic [PULSE_W-1:0] pulseCnt_reg;
	logic       sofFire;
	logic [FRAME_W-1:0] frameWindow;

	udr_sync #(.WIDTH($bits(udr_pins_t)), .RST_VAL(PINS_IDLE)) u_pin_sync (
		.clk     (clk),
		.rst     (rst),
		.pinIn   (pinIn),
		.syncOut (pins)
	);

	// The synchroniser holds its idle value for a few edges, so the strap is caught only once it has filled.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fillCnt_reg <= 3'h0;
			muxBusMode  <= 1'b0;
		end else if (fillCnt_reg != `UDR_SYNC_FILL) begin
			fillCnt_reg <= fillCnt_reg + 3'h1;
			if (fillCnt_reg == `UDR_SYNC_FILL - 3'h1) begin
				muxBusMode <= pins.busSel;
			end
		end
	end

	assign strobeLow = !pins.rdN || !pins.wrLoN || !pins.wrHiN;
	assign strobeEnd = strobeLow_reg && !strobeLow;
	assign accAddr   = muxBusMode ? muxAddr_reg : pins.wordAddr;

	// Multiplexed bus: the word address rides on the data lines while the latch strobe is high.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			muxAddr_reg <= 7'h00;
		end else if (muxBusMode && pins.ale) begin
			muxAddr_reg <= pins.hostData[7:1];
		end
	end

	// Access qualifiers are captured while the strobe is low and acted on when it rises.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			strobeLow_reg <= 1'b0;
			accRead_reg   <= 1'b0;
			accWrLo_reg   <= 1'b0;
			accWrHi_reg   <= 1'b0;
			accCs_reg     <= 1'b0;
			accDack_reg   <= 2'h0;
			wrData_reg    <= 16'h0000;
			splitWr_reg   <= 8'h00;
		end else begin
			strobeLow_reg <= strobeLow && fillCnt_reg == `UDR_SYNC_FILL;
			if (strobeLow) begin
				accRead_reg <= !pins.rdN;
				accWrLo_reg <= !pins.wrLoN;
				accWrHi_reg <= !pins.wrHiN;
				accCs_reg   <= !pins.csN;
				accDack_reg <= ~pins.dackN;
				wrData_reg  <= pins.hostData;
				splitWr_reg <= pins.splitData;
			end
		end
	end

	always_comb begin
		chanAcc[0] = strobeEnd && (dmaCfg[0].ackOnly ? accDack_reg[0] : accCs_reg && accAddr == `UDR_ADDR_DMA0_FIFO);
		chanAcc[1] = strobeEnd && (dmaCfg[1].ackOnly ? accDack_reg[1] : accCs_reg && accAddr == `UDR_ADDR_DMA1_FIFO);
	end

	// Only the three FIFO ports and acknowledge-only DMA cycles touch the packet buffer; other accesses never push or pop.
	always_comb begin
		rxPop  = 1'b0;
		txPush = 1'b0;
		txWord = swapIf(wrData_reg, byteSwap && accWrLo_reg && accWrHi_reg);
		if (strobeEnd && accCs_reg && accAddr == `UDR_ADDR_CPU_FIFO) begin
			rxPop  = accRead_reg && rxValid;
			txPush = (accWrLo_reg || accWrHi_reg) && txReady;
		end
		for (int c = 0; c < 2; c++) begin
			if (chanAcc[c] && dmaCfg[c].source != `UDR_SRC_OFF) begin
				rxPop  = accRead_reg && rxValid;
				txPush = (accWrLo_reg || accWrHi_reg) && txReady;
				if (dmaCfg[c].ackOnly) begin
					txWord = {8'h00, splitWr_reg};
				end
			end
		end
	end

	assign fifoFlush = usbRxZlp && ((dmaCfg[0].source != `UDR_SRC_OFF && dmaCfg[0].pipe == usbPipe)
		|| (dmaCfg[1].source != `UDR_SRC_OFF && dmaCfg[1].pipe == usbPipe));

	udr_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.clk      (clk),
		.rst      (rst),
		.flush    (fifoFlush),
		.inValid  (usbRxValid),
		.inData   (usbRxData),
		.inReady  (usbRxReady),
		.outValid (rxValid),
		.outData  (rxHead),
		.outReady (rxPop)
	);

	udr_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.clk      (clk),
		.rst      (rst),
		.flush    (1'b0),
		.inValid  (txPush),
		.inData   (txWord),
		.inReady  (txReady),
		.outValid (usbTxValid),
		.outData  (usbTxData),
		.outReady (usbTxReady)
	);

	// Read data is driven only while chip select and read strobe are both seen low.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hostDataOut <= 16'h0000;
			hostDataOe  <= 1'b0;
		end else begin
			hostDataOe <= !pins.csN && !pins.rdN && !pins.ale;
			if (accAddr == `UDR_ADDR_STATUS) begin
				hostDataOut <= {10'h000, txReady, rxValid, muxBusMode, speed, hostRole};
			end else begin
				hostDataOut <= swapIf(rxHead, byteSwap);
			end
		end
	end

	for (genvar c = 0; c < 2; c++) begin : g_dma
		udr_dma_state_t state_reg;
		udr_dma_state_t state_next;
		logic           endSeen;

		// A channel with source off never requests, which is how an unused acknowledge pin is parked.
		assign chanReady[c] = dmaCfg[c].source != `UDR_SRC_OFF && dmaCfg[c].pipe == usbPipe
			&& (accRead_reg ? rxValid : txReady);
		assign endSeen = dmaCfg[c].endEnable && !pins.dendN[c];

		always_comb begin
			state_next = state_reg;
			case (state_reg)
				DMA_IDLE: begin
					if (chanReady[c]) begin
						state_next = DMA_REQ;
					end
				end
				DMA_REQ: begin
					if (endSeen) begin
						state_next = DMA_DONE;
					end else if (!chanReady[c]) begin
						state_next = dmaCfg[c].burst ? DMA_DONE : DMA_IDLE;
					end else if (chanAcc[c] && !dmaCfg[c].burst) begin
						state_next = DMA_GAP;
					end
				end
				DMA_GAP: begin
					state_next = strobeLow ? DMA_GAP : DMA_IDLE;
				end
				DMA_DONE: begin
					state_next = DMA_IDLE;
				end
				default: begin
					state_next = DMA_IDLE;
				end
			endcase
		end

		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				state_reg  <= DMA_IDLE;
				dmaReqN[c] <= 1'b1;
			end else begin
				state_reg  <= state_next;
				dmaReqN[c] <= state_next != DMA_REQ;
			end
		end
		assign chanEnd[c] = state_reg == DMA_REQ && state_next == DMA_DONE;
	end

	// Split-bus read data: the setup bit drives it from the acknowledge edge instead of waiting for the strobe.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			splitDataOut <= 8'h00;
			splitDataOe  <= 1'b0;
		end else begin
			splitDataOut <= rxHead[7:0];
			splitDataOe  <= (!pins.dackN[0] && dmaCfg[0].ackOnly && (dmaCfg[0].outSetup || !pins.rdN))
				|| (!pins.dackN[1] && dmaCfg[1].ackOnly && (dmaCfg[1].outSetup || !pins.rdN));
		end
	end

	// Speed is decided when bus reset ends; a chirp during reset means high speed.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			chirp_reg     <= 1'b0;
			resetPrev_reg <= 1'b0;
			speed         <= SPD_FULL;
		end else begin
			resetPrev_reg <= busResetActive;
			if (busResetActive) begin
				chirp_reg <= chirp_reg || chirpSeen;
			end else if (resetPrev_reg) begin
				chirp_reg <= 1'b0;
				if (chirp_reg) begin
					speed <= SPD_HIGH;
				end else if (hostRole && lineDm && !lineDp) begin
					speed <= SPD_LOW;
				end else begin
					speed <= SPD_FULL;
				end
			end
		end
	end

	assign frameWindow = FRAME_W'((speed == SPD_HIGH ? HS_FRAME_CYC : FS_FRAME_CYC) + `UDR_SOF_SLACK_CYC);
	assign sofFire = hostRole ? sofSent : (sofRxGood || (frameLock_reg && frameCnt_reg == frameWindow));

	// A bad SOF does not restart the timer, so the interpolated pulse follows one window after the last good one.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			frameCnt_reg  <= '0;
			frameLock_reg <= 1'b0;
		end else if (hostRole || busResetActive) begin
			frameCnt_reg  <= '0;
			frameLock_reg <= 1'b0;
		end else if (sofFire) begin
			frameCnt_reg  <= '0;
			frameLock_reg <= 1'b1;
		end else begin
			frameCnt_reg <= frameCnt_reg + FRAME_W'(1);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pulseCnt_reg <= '0;
			sofPulseN    <= 1'b1;
		end else if (sofFire) begin
			pulseCnt_reg <= PULSE_W'(`UDR_SOF_PULSE_CYC - 1);
			sofPulseN    <= 1'b0;
		end else if (pulseCnt_reg != '0) begin
			pulseCnt_reg <= pulseCnt_reg - PULSE_W'(1);
		end else begin
			sofPulseN <= 1'b1;
		end
	end

	assign eventSet = {sofRxBad && !hostRole, fifoFlush, chanEnd, !busResetActive && resetPrev_reg, sofFire};

	// Event flags: a set in the cycle of a clear wins, so no event is lost.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			eventStatus <= 6'h00;
			irqN        <= 1'b1;
		end else begin
			eventStatus <= (eventStatus & ~eventClear) | eventSet;
			irqN        <= ~|(((eventStatus & ~eventClear) | eventSet) & eventEnable);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			usbPipeKind  <= PK_CTRL;
			usbDoubleBuf <= 1'b0;
		end else begin
			usbPipeKind  <= pipeKind(usbPipe);
			usbDoubleBuf <= pipeKind(usbPipe) == PK_BULK
				|| (pipeKind(usbPipe) == PK_SELECT && !isoSelect[usbPipe[0]]);
		end
	end

	// The PLL multiplier must match the reference actually fitted; code 3 is refused and flagged.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pllMult     <= `UDR_PLL_MULT_12;
			pllCfgError <= 1'b0;
		end else begin
			pllCfgError <= 1'b0;
			case (refClkSel)
				`UDR_REF_12MHZ: pllMult <= `UDR_PLL_MULT_12;
				`UDR_REF_24MHZ: pllMult <= `UDR_PLL_MULT_24;
				`UDR_REF_48MHZ: pllMult <= `UDR_PLL_MULT_48;
				default: pllCfgError <= 1'b1;
			endcase
		end
	end
	// Role selection is the hostRole input; it steers SOF source, speed detection and status.
endmodule : udr_host_if

// ### verification/udr_host_if_chk.sv
// Port-level checks for udr_host_if, bound to every instance.
// Assumes one clock domain with rst as its reset.
`timescale 1ns/1ps
module udr_host_if_chk
	import udr_pkg::*;
(
	// Clock, reset and inputs.
	input wire logic               clk,
	input wire logic               rst,
	input wire udr_pins_t          pinIn,
	input wire logic               hostRole,
	input wire logic               sofSent,
	input wire udr_dma_cfg_t [1:0] dmaCfg,
	input wire logic [1:0]         refClkSel,
	input wire logic [5:0]         eventEnable,
	input wire logic [5:0]         eventClear,
	input wire logic [3:0]         usbPipe,
	// Outputs.
	input wire logic [1:0]         dmaReqN,
	input wire logic               sofPulseN,
	input wire logic               irqN,
	input wire logic [5:0]         eventStatus,
	input wire logic [5:0]         pllMult,
	input wire udr_pipe_kind_t     usbPipeKind
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	function automatic udr_pipe_kind_t kindOf(input logic [3:0] p);
		return (p == 4'h0) ? PK_CTRL : (p <= 4'h2) ? PK_SELECT : (p <= 4'h5) ? PK_BULK : PK_INTR;
	endfunction : kindOf
	sequence s_ackWrite; !pinIn.dackN[0] && !pinIn.wrLoN; endsequence
	sequence s_release; pinIn.wrLoN; endsequence
	property p_hostSof; hostRole && sofSent |-> ##[1:2] !sofPulseN; endproperty
	property p_sofWidth; $fell(sofPulseN) |-> !sofPulseN[*8]; endproperty
	property p_irq; irqN == !(|(eventStatus & $past(eventEnable))); endproperty
	property p_sticky; eventStatus[0] && !eventClear[0] |=> eventStatus[0]; endproperty
	property p_pll; refClkSel != 2'h3 |=> pllMult == (6'h28 >> $past(refClkSel)); endproperty
	property p_pipe; !rst && usbPipe < 4'hA |=> usbPipeKind == kindOf($past(usbPipe)); endproperty
	property p_dmaOff; dmaCfg[1].source == 3'h0 |=> dmaReqN[1]; endproperty
	property p_steal; !dmaCfg[0].burst throughout (s_ackWrite ##1 s_release) |-> ##[1:8] dmaReqN[0]; endproperty
	a_hostSof: assert property (p_hostSof) else $error("no frame pulse");
	a_sofWidth: assert property (p_sofWidth) else $error("frame pulse short");
	a_irq: assert property (p_irq) else $error("irq mismatch");
	a_sticky: assert property (p_sticky) else $error("event lost");
	a_pll: assert property (p_pll) else $error("pll factor");
	a_pipe: assert property (p_pipe) else $error("pipe kind");
	a_dmaOff: assert property (p_dmaOff) else $error("idle channel requests");
	a_steal: assert property (p_steal) else $error("no request gap");
endmodule : udr_host_if_chk
bind udr_host_if udr_host_if_chk i_chk (.clk(clk), .rst(rst), .pinIn(pinIn), .hostRole(hostRole), .sofSent(sofSent),
	.dmaCfg(dmaCfg), .refClkSel(refClkSel), .eventEnable(eventEnable), .eventClear(eventClear), .usbPipe(usbPipe),
	.dmaReqN(dmaReqN), .sofPulseN(sofPulseN), .irqN(irqN), .eventStatus(eventStatus), .pllMult(pllMult),
	.usbPipeKind(usbPipeKind));

// ### verification/udr_dma_model.sv
// Behavioural DMA controller: cycle-steal byte writes with acknowledge on channel 0.
// Assumes the bench merges its strobe, acknowledge and data into the device pins.
`timescale 1ns/1ps
module udr_dma_model (
	// Clock and enable.
	input  wire logic       clk,
	input  wire logic       en,
	// Device side.
	input  wire logic       reqN,
	output logic            ackN,
	output logic            wrN,
	output logic      [7:0] data,
	output int              sent
);
	initial begin
		ackN = 1'b1;
		wrN = 1'b1;
		data = 8'hFF;
		sent = 0;
		forever begin
			@(posedge clk);
			if (en && !reqN) begin
				ackN <= 1'b0;
				wrN <= 1'b0;
				data <= sent[7:0];
				repeat (6) @(posedge clk);
				ackN <= 1'b1;
				wrN <= 1'b1;
				data <= ~sent[7:0];
				sent <= sent + 1;
				// Long idle lets the request gap settle before the next look.
				repeat (8) @(posedge clk);
			end
		end
	end
endmodule : udr_dma_model

// ### verification/udr_host_if_bench.sv
// Bench for udr_host_if: CPU FIFO access, frame pulse, events, PLL setup, DMA fill to full.
// Assumes the checker is bound and the DMA model serves channel 0.
`timescale 1ns/1ps
module udr_host_if_bench
	import udr_pkg::*;
;
	logic clk, rst, hostRole, byteSwap, usbRxValid, usbTxReady, sofSent, dmaEn, usbTxValid, sofPulseN, irqN;
	logic muxBusMode, mAckN, mWrN;
	logic usbRxZlp, chirpSeen, busResetActive, sofRxGood, sofRxBad, pllCfgError, busSelPin, aleHi;
	logic [15:0] usbRxData, usbTxData, hostDataOut, rdVal;
	logic [7:0] mData;
	logic [5:0] eventEnable, eventClear, eventStatus, pllMult;
	logic [3:0] usbPipe;
	logic [1:0] refClkSel, dmaReqN;
	udr_dma_cfg_t [1:0] dmaCfg;
	udr_pins_t pins, pinsIn;
	int errTotal, checksDone, sent;
	always_comb begin
		pinsIn = pins;
		pinsIn.dackN[0] = mAckN;
		pinsIn.wrLoN = pins.wrLoN & mWrN;
		pinsIn.splitData = mData;
		pinsIn.ale = aleHi;
		pinsIn.busSel = busSelPin;
	end
	udr_host_if #(.FS_FRAME_CYC(200), .HS_FRAME_CYC(50)) i_dut (.clk(clk), .rst(rst), .pinIn(pinsIn),
		.hostDataOut(hostDataOut), .hostDataOe(), .splitDataOut(), .splitDataOe(), .dmaReqN(dmaReqN),
		.sofPulseN(sofPulseN), .irqN(irqN), .hostRole(hostRole), .byteSwap(byteSwap), .dmaCfg(dmaCfg),
		.isoSelect(2'h0), .refClkSel(refClkSel), .eventEnable(eventEnable), .eventClear(eventClear),
		.eventStatus(eventStatus), .speed(), .muxBusMode(muxBusMode), .pllMult(pllMult), .pllCfgError(pllCfgError),
		.usbPipeKind(), .usbDoubleBuf(), .usbPipe(usbPipe), .usbRxValid(usbRxValid), .usbRxData(usbRxData),
		.usbRxReady(), .usbRxZlp(usbRxZlp), .usbTxValid(usbTxValid), .usbTxData(usbTxData), .usbTxReady(usbTxReady),
		.lineDp(1'b1), .lineDm(1'b0), .chirpSeen(chirpSeen), .busResetActive(busResetActive), .sofSent(sofSent),
		.sofRxGood(sofRxGood), .sofRxBad(sofRxBad));
	udr_dma_model i_dma (.clk(clk), .en(dmaEn), .reqN(dmaReqN[0]), .ackN(mAckN), .wrN(mWrN), .data(mData),
		.sent(sent));
	// Bus type select changes only while reset is held; the latch strobe comes from aleHi.
	function automatic udr_pins_t mkPins(input logic cs, rd, wr, input logic [6:0] a, input logic [15:0] d);
		return '{csN: cs, rdN: rd, wrLoN: wr, wrHiN: wr, ale: 1'b0, busSel: 1'b0, dackN: 2'h3, dendN: 2'h3,
			wordAddr: a, hostData: d, splitData: 8'h00};
	endfunction : mkPins
	task automatic chk(input logic [15:0] got, exp);
		checksDone++;
		if (got !== exp) begin
			errTotal++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic cpuAcc(input logic [6:0] a, input logic [15:0] d, input logic rd);
		@(posedge clk);
		pins <= mkPins(1'b0, !rd, rd, a, d);
		repeat (7) @(posedge clk);
		rdVal = hostDataOut;
		pins <= mkPins(1'b1, 1'b1, 1'b1, a, ~d);
		repeat (8) @(posedge clk);
	endtask : cpuAcc
	task automatic popTx;
		usbTxReady <= 1'b1;
		@(posedge clk);
		usbTxReady <= 1'b0;
		@(posedge clk);
	endtask : popTx
	task automatic testDone;
		$display("checks %0d mismatches %0d", checksDone, errTotal);
		if (errTotal == 0 && checksDone > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : testDone
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		repeat (6000) @(posedge clk);
		errTotal++;
		testDone;
	end
	initial begin
		{rst, hostRole, byteSwap, usbRxValid, usbTxReady, sofSent, dmaEn} = 7'h40;
		{usbRxZlp, chirpSeen, busResetActive, sofRxGood, sofRxBad, busSelPin, aleHi} = 7'h00;
		pins = mkPins(1'b1, 1'b1, 1'b1, 7'h00, 16'h0000);
		{usbRxData, eventEnable, eventClear, refClkSel, usbPipe} = {16'h0000, 12'h000, 2'h0, 4'h3};
		dmaCfg = '0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (6) @(posedge clk);
		chk(16'(muxBusMode), 16'h0000);
		cpuAcc(7'h10, 16'hA55A, 1'b0);
		chk(usbTxData, 16'hA55A);
		popTx;
		byteSwap <= 1'b1;
		cpuAcc(7'h10, 16'h1234, 1'b0);
		chk(usbTxData, 16'h3412);
		popTx;
		{byteSwap, usbRxValid, usbRxData} <= {2'h1, 16'hBEEF};
		@(posedge clk);
		usbRxValid <= 1'b0;
		cpuAcc(7'h10, 16'h0000, 1'b1);
		chk(rdVal, 16'hBEEF);
		hostRole <= 1'b1;
		cpuAcc(7'h00, 16'h0000, 1'b1);
		chk(16'(rdVal[0]), 16'h0001);
		$display("cpu test done");
		{eventEnable, sofSent} <= 7'h03;
		@(posedge clk);
		sofSent <= 1'b0;
		repeat (3) @(posedge clk);
		chk({sofPulseN, irqN, 8'h00, eventStatus}, 16'h0001);
		eventClear <= 6'h01;
		@(posedge clk);
		eventClear <= 6'h00;
		repeat (2) @(posedge clk);
		chk(16'(irqN), 16'h0001);
		for (int s = 0; s < 4; s++) begin
			refClkSel <= 2'(s);
			repeat (3) @(posedge clk);
			chk(16'({pllCfgError, pllMult}), (s == 3) ? 16'h004A : 16'(6'h28 >> s));
		end
		for (int p = 9; p >= 0; p--) begin
			usbPipe <= 4'(p);
			@(posedge clk);
		end
		{usbPipe, hostRole, busResetActive, chirpSeen} <= 7'h1B;
		@(posedge clk);
		{busResetActive, chirpSeen, sofRxGood} <= 3'h1;
		@(posedge clk);
		{sofRxGood, sofRxBad} <= 2'h1;
		@(posedge clk);
		{sofRxBad, eventClear} <= 7'h01;
		@(posedge clk);
		eventClear <= 6'h00;
		repeat (108) @(posedge clk);
		chk({sofPulseN, 9'h000, eventStatus}, 16'h8022);
		repeat (8) @(posedge clk);
		chk({sofPulseN, 9'h000, eventStatus}, 16'h0023);
		$display("event test done");
		cpuAcc(7'h00, 16'h0000, 1'b0);
		dmaCfg[0] <= '{source: 3'h1, ackOnly: 1'b1, endEnable: 1'b0, burst: 1'b0, outSetup: 1'b0, pipe: 4'h3};
		dmaEn <= 1'b1;
		for (int i = 0; i < 900 && sent < 16; i++) @(posedge clk);
		repeat (30) @(posedge clk);
		dmaEn <= 1'b0;
		chk(16'(sent), 16'd16);
		chk(16'(dmaReqN[0]), 16'h0001);
		for (int i = 0; i < 16; i++) begin
			chk(16'(usbTxData[7:0]), 16'(i));
			popTx;
		end
		chk(16'(usbTxValid), 16'h0000);
		usbRxValid <= 1'b1;
		@(posedge clk);
		{usbRxValid, usbRxZlp} <= 2'h1;
		@(posedge clk);
		usbRxZlp <= 1'b0;
		@(posedge clk);
		chk(16'(eventStatus[4]), 16'h0001);
		cpuAcc(7'h00, 16'h0000, 1'b1);
		chk(rdVal, 16'h0022);
		$display("dma test done");
		{busSelPin, rst} <= 2'h3;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (6) @(posedge clk);
		chk(16'(muxBusMode), 16'h0001);
		{aleHi, pins} <= {1'b1, mkPins(1'b1, 1'b1, 1'b1, 7'h00, 16'h0020)};
		repeat (6) @(posedge clk);
		aleHi <= 1'b0;
		cpuAcc(7'h00, 16'h5AA5, 1'b0);
		chk(usbTxData, 16'h5AA5);
		$display("mux test done");
		testDone;
	end
endmodule : udr_host_if_bench
